// *** swl_top.sv ***
/*
 * swl_top: bus reset and single-bit slot engine of a host to single-wire bridge.
 * Commands arrive on the serial clock; the line runs on the 20 MHz core clock.
 * Assumes an open-drain line with an external pull-up and a command source
 * that presents one byte pair per strobe.
 */
// Behaviour
// - The reset command code starts a full reset and presence-detect cycle on the line.
// - During reset the line is sampled twice and reported as presence and short bits.
// - A reset code arriving while the line is busy is not acknowledged and is dropped.
// - Reset line activity starts within 262.5ns and lasts low time plus high time.
// - After a reset or single-bit command the read pointer rests on the status register.
// - The single-bit value comes from bit 7 of the parameter; the other bits are ignored.
// - Value 0 makes a write-zero slot and value 1 a write-one slot that also reads.
// - Both slot kinds sample the line at bit sample time into the single-bit result.
// - A single-bit code arriving while busy is refused with its parameter and dropped.
// - Slot activity starts within 262.5ns and lasts one slot time.
// - A single-bit command may change the branch direction bit as well as busy and result.
// - A configuration write takes effect at once if the line is not busy, and only if the high nibble inverts the low.
`timescale 1ns/100ps
module swl_top
   import swl_pkg::*;
#(
   parameter logic [CNT_W-1:0] RST_LOW_CYC = RST_LOW_STD_CYC,
   parameter logic [CNT_W-1:0] RST_HIGH_CYC = RST_HIGH_STD_CYC
) (
   // clocks and reset
   input wire logic core_clk_i,
   input wire logic ser_clk_i,
   input wire logic arst_n_i,
   // host commands, serial clock domain
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [7:0] cmd_param_i,
   output logic cmd_ack_o,
   output logic cmd_nak_o,
   output logic read_ptr_status_o,
   output logic [3:0] cfg_o,
   // status, core clock domain
   output logic line_busy_o,
   output logic presence_detected_o,
   output logic short_detected_o,
   output logic single_bit_result_o,
   output logic branch_direction_o,
   // single-wire line
   input wire logic line_i,
   output logic line_o,
   output logic line_oe_o,
   output logic active_pullup_o,
   output logic strong_pullup_o
);

   localparam int ACT_MAX = ACT_DELAY_CYC;

   // ************************************************************
   // serial domain: command intake
   // ************************************************************
   logic pending_r;
   logic req_tgl_r;
   logic req_slot_r;
   logic req_bit_r;
   logic done_seen_r;
   logic done_q;
   logic line_cmd_c;
   logic accept_c;
   logic cfg_ok_c;
   logic done_c;

   // busy is judged locally so a back-to-back code cannot slip in before busy syncs
   assign line_cmd_c = (cmd_code_i == CMD_BUS_RESET) || (cmd_code_i == CMD_SINGLE_BIT);
   assign accept_c = cmd_valid_i && !pending_r
                     && (line_cmd_c || (cmd_code_i == CMD_WRITE_CFG));
   assign cfg_ok_c = (cmd_param_i[7:4] == ~cmd_param_i[3:0]);
   assign done_c = (done_q != done_seen_r);

   always_ff @(posedge ser_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_ack_o <= 1'b0;
         cmd_nak_o <= 1'b0;
      end else begin
         cmd_ack_o <= accept_c;
         cmd_nak_o <= cmd_valid_i && !accept_c;
      end
   end

   always_ff @(posedge ser_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pending_r <= 1'b0;
         req_tgl_r <= 1'b0;
         req_slot_r <= 1'b0;
         req_bit_r <= 1'b0;
         done_seen_r <= 1'b0;
      end else begin
         if (done_c) begin
            done_seen_r <= done_q;
         end
         if (accept_c && line_cmd_c) begin
            pending_r <= 1'b1;
            req_tgl_r <= ~req_tgl_r;
            req_slot_r <= (cmd_code_i == CMD_SINGLE_BIT);
            req_bit_r <= cmd_param_i[SLOT_VALUE_BIT];
         end else if (done_c) begin
            pending_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge ser_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_o <= CFG_RESET;
      end else if (accept_c && (cmd_code_i == CMD_WRITE_CFG) && cfg_ok_c) begin
         cfg_o <= cmd_param_i[3:0];
      end
   end

   always_ff @(posedge ser_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         read_ptr_status_o <= PTR_STATUS_RESET;
      end else if (accept_c) begin
         read_ptr_status_o <= line_cmd_c;
      end
   end

   // ************************************************************
   // crossings
   // ************************************************************
   logic done_tgl_r;
   logic req_q;
   logic req_seen_r;
   logic [3:0] cfg_q;
   logic line_q2;
   logic line_q3;
   logic line_lvl_r;

   swl_sync #(.WIDTH(1)) u_done_sync (
      .clk_i(ser_clk_i),
      .arst_n_i(arst_n_i),
      .d_i(done_tgl_r),
      .q2_o(done_q),
      .q3_o()
   );

   swl_sync #(.WIDTH(5)) u_req_sync (
      .clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .d_i({cfg_o, req_tgl_r}),
      .q2_o({cfg_q, req_q}),
      .q3_o()
   );

   swl_sync #(.WIDTH(1)) u_line_sync (
      .clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .d_i(!line_i),
      .q2_o(line_q2),
      .q3_o(line_q3)
   );

   // chain holds the line inverted, so its cleared reset reads as idle high, no false low
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         line_lvl_r <= 1'b1;
      end else if (line_q2 == line_q3) begin
         line_lvl_r <= !line_q2;
      end
   end

   // ************************************************************
   // core domain: sequencer
   // ************************************************************
   swl_state_type state_r;
   logic [CNT_W-1:0] cnt_r;
   logic slot_bit_r;
   logic go_c;
   logic od_c;
   logic ppm_c;
   logic [CNT_W-1:0] rst_low_c;
   logic [CNT_W-1:0] rst_high_c;
   logic [CNT_W-1:0] short_c;
   logic [CNT_W-1:0] pres_c;
   logic [CNT_W-1:0] slot_c;
   logic [CNT_W-1:0] low_c;
   logic [CNT_W-1:0] msr_c;
   logic drive_c;
   logic short_smp_c;
   logic pres_smp_c;
   logic bit_smp_c;
   logic end_c;

   // slot data is read raw: it stays still from toggle until done returns
   assign go_c = (req_q != req_seen_r) && (state_r == ST_IDLE);
   assign od_c = cfg_q[CFG_SPEED_BIT];
   assign ppm_c = cfg_q[CFG_PPM_BIT];
   assign rst_low_c = od_c ? RST_LOW_OD_CYC : RST_LOW_CYC;
   assign rst_high_c = od_c ? RST_HIGH_OD_CYC : RST_HIGH_CYC;
   assign short_c = od_c ? SHORT_OD_CYC : SHORT_STD_CYC;
   assign pres_c = od_c ? PRES_OD_CYC : PRES_STD_CYC;
   assign slot_c = od_c ? SLOT_OD_CYC : SLOT_STD_CYC;
   assign msr_c = od_c ? BIT_SAMPLE_OD_CYC : BIT_SAMPLE_STD_CYC;
   assign low_c = slot_bit_r ? (od_c ? W1_OD_CYC : W1_STD_CYC)
                             : (od_c ? W0_OD_CYC : W0_STD_CYC);
   assign short_smp_c = (state_r == ST_RST_HIGH) && (cnt_r == short_c - 16'h0001);
   assign pres_smp_c = (state_r == ST_RST_HIGH) && (cnt_r == pres_c - 16'h0001);
   assign bit_smp_c = (state_r == ST_SLOT) && (cnt_r == msr_c - 16'h0001);
   assign end_c = ((state_r == ST_RST_HIGH) && (cnt_r == rst_high_c - 16'h0001))
                  || ((state_r == ST_SLOT) && (cnt_r == slot_c - 16'h0001));

   always_comb begin
      case (state_r)
         ST_RST_LOW: drive_c = 1'b1;
         // masking keeps the line low past the slave's falling edge
         ST_RST_HIGH: drive_c = ppm_c && (cnt_r < short_c);
         ST_SLOT: drive_c = (cnt_r < low_c);
         default: drive_c = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ST_IDLE;
         cnt_r <= 16'h0000;
         req_seen_r <= 1'b0;
         slot_bit_r <= 1'b0;
         done_tgl_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               cnt_r <= 16'h0000;
               if (go_c) begin
                  req_seen_r <= req_q;
                  slot_bit_r <= req_bit_r;
                  state_r <= req_slot_r ? ST_SLOT : ST_RST_LOW;
               end
            end
            ST_RST_LOW: begin
               if (cnt_r == rst_low_c - 16'h0001) begin
                  cnt_r <= 16'h0000;
                  state_r <= ST_RST_HIGH;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            ST_RST_HIGH, ST_SLOT: begin
               cnt_r <= cnt_r + 16'h0001;
               if (end_c) begin
                  state_r <= ST_IDLE;
                  done_tgl_r <= ~done_tgl_r;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ************************************************************
   // core domain: status and line drive
   // ************************************************************
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         line_busy_o <= 1'b0;
      end else if (go_c) begin
         line_busy_o <= 1'b1;
      end else if (end_c) begin
         line_busy_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         presence_detected_o <= 1'b0;
         short_detected_o <= 1'b0;
      end else begin
         if (short_smp_c) begin
            // under masking we hold the line ourselves, so no short can be seen
            short_detected_o <= !ppm_c && !line_lvl_r;
         end
         if (pres_smp_c) begin
            presence_detected_o <= !line_lvl_r;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         single_bit_result_o <= 1'b0;
         branch_direction_o <= 1'b0;
      end else if (bit_smp_c) begin
         single_bit_result_o <= line_lvl_r;
         branch_direction_o <= line_lvl_r;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         line_o <= 1'b0;
         line_oe_o <= 1'b0;
         active_pullup_o <= 1'b0;
         strong_pullup_o <= 1'b0;
      end else begin
         line_o <= 1'b0;
         line_oe_o <= drive_c;
         active_pullup_o <= cfg_q[CFG_APU_BIT] && (state_r != ST_IDLE) && !drive_c;
         if (go_c) begin
            strong_pullup_o <= 1'b0;
         end else if (end_c && (state_r == ST_SLOT)) begin
            strong_pullup_o <= cfg_q[CFG_SPU_BIT];
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   AST_RESET_DRIVES: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (go_c && !req_slot_r) |-> ##[1:ACT_MAX] line_oe_o)
      else $error("reset did not drive the line in time");

   AST_SLOT_DRIVES: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (go_c && req_slot_r) |-> ##[1:ACT_MAX] line_oe_o)
      else $error("slot did not drive the line in time");

   AST_BUSY_WHOLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (state_r != ST_IDLE) |-> line_busy_o)
      else $error("busy low during line activity");

   AST_BUSY_ENDS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      end_c |=> (!line_busy_o && (state_r == ST_IDLE)))
      else $error("busy outlived the command");

   AST_SHORT_SAMPLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (short_smp_c && !ppm_c) |=> (short_detected_o == !$past(line_lvl_r)))
      else $error("short bit does not match line");

   AST_PRES_SAMPLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      pres_smp_c |=> (presence_detected_o == !$past(line_lvl_r)))
      else $error("presence bit does not match line");

   AST_BIT_SAMPLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      bit_smp_c |=> ((single_bit_result_o == $past(line_lvl_r))
                     && (branch_direction_o == single_bit_result_o)))
      else $error("slot result does not match line");

   AST_W1_RELEASE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      ((state_r == ST_SLOT) && slot_bit_r && (cnt_r == low_c)) |=> !line_oe_o)
      else $error("write-one slot held the line too long");

   AST_BUSY_REFUSED: assert property (@(posedge ser_clk_i) disable iff (!arst_n_i)
      (cmd_valid_i && pending_r && line_cmd_c) |=> (cmd_nak_o && !cmd_ack_o && $stable(req_tgl_r)))
      else $error("busy command was not refused");

   AST_SLOT_VALUE: assert property (@(posedge ser_clk_i) disable iff (!arst_n_i)
      (accept_c && (cmd_code_i == CMD_SINGLE_BIT))
      |=> (req_bit_r == $past(cmd_param_i[SLOT_VALUE_BIT])))
      else $error("slot value not taken from bit 7");

   AST_CFG_CHECK: assert property (@(posedge ser_clk_i) disable iff (!arst_n_i)
      (accept_c && (cmd_code_i == CMD_WRITE_CFG))
      |=> (cfg_o == ($past(cfg_ok_c) ? $past(cmd_param_i[3:0]) : $past(cfg_o))))
      else $error("configuration check wrong");

   AST_PTR_STATUS: assert property (@(posedge ser_clk_i) disable iff (!arst_n_i)
      (accept_c && line_cmd_c) |=> read_ptr_status_o)
      else $error("pointer left off status");

   COV_RESET: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
      pres_smp_c ##1 presence_detected_o);
   COV_READ_ZERO: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
      bit_smp_c && slot_bit_r && !line_lvl_r);
   COV_REFUSED: cover property (@(posedge ser_clk_i) disable iff (!arst_n_i)
      cmd_valid_i && pending_r);
   COV_BAD_CFG: cover property (@(posedge ser_clk_i) disable iff (!arst_n_i)
      accept_c && (cmd_code_i == CMD_WRITE_CFG) && !cfg_ok_c);

endmodule

// *** swl_pkg.sv ***
/*
 * swl_pkg: constants and types shared by the single-wire reset and bit-slot engine.
 * Assumes a 20 MHz core clock; every slot time is derived from its figure in ns.
 */
package swl_pkg;

   // ************************************************************
   // clock and start latency
   // ************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam real ACT_DELAY_NS = 262.5;
   localparam int ACT_DELAY_CYC = int'($floor(ACT_DELAY_NS / CLK_PERIOD_NS));

   // ************************************************************
   // command codes and parameter fields
   // ************************************************************
   localparam logic [7:0] CMD_BUS_RESET = 8'hB4;
   localparam logic [7:0] CMD_SINGLE_BIT = 8'h87;
   localparam logic [7:0] CMD_WRITE_CFG = 8'hD2;
   localparam int SLOT_VALUE_BIT = 7;

   // ************************************************************
   // configuration field positions and reset value
   // ************************************************************
   localparam int CFG_APU_BIT = 0;
   localparam int CFG_PPM_BIT = 1;
   localparam int CFG_SPU_BIT = 2;
   localparam int CFG_SPEED_BIT = 3;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam logic PTR_STATUS_RESET = 1'b1;

   // ************************************************************
   // slot times in ns, standard and overdrive
   // ************************************************************
   localparam int RST_LOW_STD_NS = 560000;
   localparam int RST_HIGH_STD_NS = 560000;
   localparam int RST_LOW_OD_NS = 68000;
   localparam int RST_HIGH_OD_NS = 68000;
   localparam int SHORT_SAMPLE_STD_NS = 8000;
   localparam int SHORT_SAMPLE_OD_NS = 1000;
   localparam int PRES_SAMPLE_STD_NS = 68000;
   localparam int PRES_SAMPLE_OD_NS = 8000;
   localparam int SLOT_STD_NS = 70000;
   localparam int SLOT_OD_NS = 10000;
   localparam int W0_LOW_STD_NS = 64000;
   localparam int W0_LOW_OD_NS = 8000;
   localparam int W1_LOW_STD_NS = 8000;
   localparam int W1_LOW_OD_NS = 1000;
   localparam int BIT_SAMPLE_STD_NS = 14000;
   localparam int BIT_SAMPLE_OD_NS = 2000;

   // ************************************************************
   // the same times in core cycles
   // ************************************************************
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] RST_LOW_STD_CYC = 16'(RST_LOW_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RST_HIGH_STD_CYC = 16'(RST_HIGH_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RST_LOW_OD_CYC = 16'(RST_LOW_OD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RST_HIGH_OD_CYC = 16'(RST_HIGH_OD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SHORT_STD_CYC = 16'(SHORT_SAMPLE_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SHORT_OD_CYC = 16'(SHORT_SAMPLE_OD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] PRES_STD_CYC = 16'(PRES_SAMPLE_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] PRES_OD_CYC = 16'(PRES_SAMPLE_OD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SLOT_STD_CYC = 16'(SLOT_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SLOT_OD_CYC = 16'(SLOT_OD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] W0_STD_CYC = 16'(W0_LOW_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] W0_OD_CYC = 16'(W0_LOW_OD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] W1_STD_CYC = 16'(W1_LOW_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] W1_OD_CYC = 16'(W1_LOW_OD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] BIT_SAMPLE_STD_CYC = 16'(BIT_SAMPLE_STD_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] BIT_SAMPLE_OD_CYC = 16'(BIT_SAMPLE_OD_NS / CLK_PERIOD_NS);

   // ************************************************************
   // sequencer states
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RST_LOW = 2'b01,
      ST_RST_HIGH = 2'b10,
      ST_SLOT = 2'b11
   } swl_state_type;

endpackage

// *** swl_sync.sv ***
/*
 * swl_sync: three-stage synchroniser, one chain per bit.
 * Assumes the input is a level or a toggle from another domain.
 */
`timescale 1ns/100ps
module swl_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q2_o,
   output logic [WIDTH-1:0] q3_o
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // ************************************************************
   // chains
   // ************************************************************
   // first stage feeds only the second
   for (genvar gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            s1_r[gi] <= 1'b0;
            s2_r[gi] <= 1'b0;
            s3_r[gi] <= 1'b0;
         end else begin
            s1_r[gi] <= d_i[gi];
            s2_r[gi] <= s1_r[gi];
            s3_r[gi] <= s2_r[gi];
         end
      end
   end

   assign q2_o = s2_r;
   assign q3_o = s3_r;

endmodule

// *** swl_slave_model.sv ***
/*
 * swl_slave_model: behavioural slave on the single-wire line.
 * Assumes the bench resolves the wire with a pull-up from line_oe_i and pull_o.
 */
`timescale 1ns/100ps
module swl_slave_model (
   // line as seen by the slave
   input wire logic line_oe_i,
   // 0 absent, 1 present, 2 shorted line, 3 present and answers zero
   input wire logic [1:0] mode_i,
   output logic pull_o
);
   realtime fell_t = 0.0;
   logic pres_r = 1'b0;
   logic read0_r = 1'b0;
   // *****************************
   // pull-down, released means high
   // *****************************
   assign pull_o = pres_r | read0_r | (mode_i == 2'h2);
   always @(posedge line_oe_i) begin
      fell_t = $realtime;
      if (mode_i == 2'h3) begin
         read0_r = 1'b1;
         #3000 read0_r = 1'b0;
      end
   end
   // presence only after a low longer than any overdrive slot low
   always @(negedge line_oe_i) begin
      if ($realtime - fell_t > 9000.0 && mode_i != 2'h0) begin
         #2000 pres_r = 1'b1;
         #7000 pres_r = 1'b0;
      end
   end
endmodule

// *** tb_top.sv ***
/*
 * tb_top: self-checking bench for swl_top with a slave model on the line.
 * Assumes overdrive timing to keep the run brief; the reset phase override
 * only shapes standard speed, so overdrive resets run their full phases.
 */
`timescale 1ns/100ps
module tb_top;
   import swl_pkg::*;
   localparam logic [CNT_W-1:0] RLEN = 16'h00C8;
   logic core_clk_i = 1'b0;
   logic ser_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic [7:0] cmd_code_i = 8'h00;
   logic [7:0] cmd_param_i = 8'h00;
   logic [1:0] mode = 2'h1;
   logic cmd_ack_o, cmd_nak_o, read_ptr_status_o, line_busy_o, presence_detected_o;
   logic short_detected_o, single_bit_result_o, branch_direction_o;
   logic line_o, line_oe_o, active_pullup_o, strong_pullup_o, pull, busy_d = 1'b0;
   logic [3:0] cfg_o;
   logic [3:0] st = 4'h0;
   logic [1:0] ack_q[$];
   logic [3:0] done_q[$];
   int err_count = 0;
   int samples_checked = 0;
   int apu_cnt = 0;
   wire line = ~(line_oe_o | pull);
   initial forever #25 core_clk_i = ~core_clk_i;
   initial begin
      #13;
      forever #80 ser_clk_i = ~ser_clk_i;
   end
   swl_top #(.RST_LOW_CYC(RLEN), .RST_HIGH_CYC(RLEN)) dut (.core_clk_i(core_clk_i),
      .ser_clk_i(ser_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
      .cmd_code_i(cmd_code_i), .cmd_param_i(cmd_param_i), .cmd_ack_o(cmd_ack_o),
      .cmd_nak_o(cmd_nak_o), .read_ptr_status_o(read_ptr_status_o), .cfg_o(cfg_o),
      .line_busy_o(line_busy_o), .presence_detected_o(presence_detected_o),
      .short_detected_o(short_detected_o), .single_bit_result_o(single_bit_result_o),
      .branch_direction_o(branch_direction_o), .line_i(line), .line_o(line_o),
      .line_oe_o(line_oe_o), .active_pullup_o(active_pullup_o),
      .strong_pullup_o(strong_pullup_o));
   swl_slave_model slave (.line_oe_i(line_oe_o), .mode_i(mode), .pull_o(pull));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic send(input logic [7:0] code, input logic [7:0] prm, input logic [1:0] an);
      ack_q.push_back(an);
      @(posedge ser_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_code_i <= code;
      cmd_param_i <= prm;
      @(posedge ser_clk_i);
      cmd_valid_i <= 1'b0;
   endtask
   // len 0 skips the duration check when refusals came in between
   task automatic wait_line(input int len);
      int n;
      int b;
      n = 0;
      b = 0;
      apu_cnt = 0;
      while (line_busy_o !== 1'b1) begin
         @(negedge core_clk_i);
         n++;
         if (n > 40) test_done_timeout();
      end
      check("start_delay", 16'(n <= 6), 16'h1);
      while (line_busy_o === 1'b1) begin
         @(negedge core_clk_i);
         b++;
         if (active_pullup_o === 1'b1) apu_cnt++;
         if (b > 30000) test_done_timeout();
      end
      if (len > 0) check("busy_len", 16'(b >= len && b <= len + 2), 16'h1);
      check("read_ptr", 16'(read_ptr_status_o), 16'h1);
      check("line_o", 16'(line_o), 16'h0);
      repeat (4) @(posedge ser_clk_i);
   endtask
   task automatic test_done_timeout();
      err_count++;
      $display("wrong value busy_wait expected done seen timeout");
      test_done();
   endtask
   task automatic cfg_write(input logic [7:0] prm, input logic [3:0] exp);
      send(CMD_WRITE_CFG, prm, 2'b10);
      @(negedge ser_clk_i);
      check("cfg", 16'(cfg_o), 16'(exp));
      check("read_ptr", 16'(read_ptr_status_o), 16'h0);
   endtask
   task automatic bus_reset(input logic [1:0] m, input logic pres, input logic shrt);
      mode = m;
      st = {pres, shrt, st[1:0]};
      done_q.push_back(st);
      send(CMD_BUS_RESET, 8'h00, 2'b10);
      wait_line(int'(RST_LOW_OD_CYC) + int'(RST_HIGH_OD_CYC));
      check("apu_cycles", 16'(apu_cnt), 16'h0);
   endtask
   // ************************************************************
   // result watchers
   // ************************************************************
   always @(negedge ser_clk_i) begin
      if (cmd_ack_o === 1'b1 || cmd_nak_o === 1'b1) begin
         if (ack_q.size() == 0) check("ack_nak", {cmd_ack_o, cmd_nak_o}, 16'h0);
         else check("ack_nak", {cmd_ack_o, cmd_nak_o}, ack_q.pop_front());
      end
   end
   always @(negedge core_clk_i) begin
      busy_d <= line_busy_o;
      if (busy_d === 1'b1 && line_busy_o === 1'b0 && done_q.size() > 0)
         check("status", {presence_detected_o, short_detected_o, single_bit_result_o,
            branch_direction_o}, done_q.pop_front());
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic v;
      logic r;
      int lw;
      void'($urandom(54));
      repeat (5) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge ser_clk_i);
      cfg_write(8'h78, 4'h8);
      cfg_write(8'h7A, 4'h8);
      $display("test config done");
      bus_reset(2'h1, 1'b1, 1'b0);
      bus_reset(2'h0, 1'b0, 1'b0);
      bus_reset(2'h2, 1'b1, 1'b1);
      cfg_write(8'h5A, 4'hA);
      bus_reset(2'h2, 1'b1, 1'b0);
      $display("test bus reset done");
      mode = 2'h1;
      done_q.push_back({2'b10, st[1:0]});
      send(CMD_BUS_RESET, 8'h00, 2'b10);
      send(CMD_BUS_RESET, 8'h00, 2'b01);
      send(CMD_SINGLE_BIT, 8'h80, 2'b01);
      send(CMD_WRITE_CFG, 8'h3C, 2'b01);
      send(8'h11, 8'h00, 2'b01);
      wait_line(0);
      check("cfg_kept", 16'(cfg_o), 16'hA);
      $display("test refusal done");
      cfg_write(8'h2D, 4'hD);
      for (int i = 0; i < 4; i++) begin
         v = i[0];
         mode = i[1] ? 2'h3 : 2'h1;
         r = v & ~i[1];
         st = {st[3:2], r, r};
         done_q.push_back(st);
         send(CMD_SINGLE_BIT, {v, 7'($urandom)}, 2'b10);
         wait_line(int'(SLOT_OD_CYC));
         check("strong_pullup", 16'(strong_pullup_o), 16'h1);
         lw = int'(SLOT_OD_CYC) - (v ? int'(W1_OD_CYC) : int'(W0_OD_CYC));
         check("apu_cycles", 16'(apu_cnt + 2 >= lw && apu_cnt <= lw + 1), 16'h1);
      end
      $display("test single bit done");
      test_done();
   end
endmodule
